// *** common/bbtc_defs.svh ***
`ifndef BBTC_DEFS_SVH
`define BBTC_DEFS_SVH

// Register byte offsets
`define BBTC_CTRL_OFS      8'h00
`define BBTC_CMD_OFS       8'h04
`define BBTC_SRC0_OFS      8'h08
`define BBTC_SRC1_OFS      8'h0C
`define BBTC_PTR_OFS       8'h10
`define BBTC_RES0_OFS      8'h14
`define BBTC_RES1_OFS      8'h18
`define BBTC_FLAGS_OFS     8'h1C
`define BBTC_IRQ_STAT_OFS  8'h20
`define BBTC_IRQ_MASK_OFS  8'h24

// CMD register start bit
`define BBTC_CMD_GO_BIT    0

// Flag bit positions
`define BBTC_FLG_ERR_BIT   0
`define BBTC_FLG_ZERO_BIT  1
`define BBTC_FLG_NEG_BIT   2

// Interrupt bit positions
`define BBTC_IRQ_DONE_BIT  0
`define BBTC_IRQ_ERR_BIT   1

// Reset values
`define BBTC_WORD_RST      16'h0000
`define BBTC_IRQ_RST       2'h0

// Conversion limits and time scale factors
`define BBTC_BCD16_MAX     16'h270F
`define BBTC_BCD32_MAX     32'h05F5E0FF
`define BBTC_SEXA_MAX      8'h59
`define BBTC_SEC_PER_HOUR  32'h00000E10
`define BBTC_SEC_PER_MIN   32'h0000003C

`endif

// *** common/bbtc_pkg.sv ***
`default_nettype none

package bbtc_pkg;

   // Conversion selection
   typedef enum logic [1:0] {
      BBTC_OP_WORD_BIN_TO_DEC,
      BBTC_OP_DWORD_DEC_TO_BIN,
      BBTC_OP_DWORD_BIN_TO_DEC,
      BBTC_OP_TIME_TO_SEC
   } bbtc_op_t;

   // Control register layout, bit 6 downward
   typedef struct packed {
      logic     ind_range_err;
      logic     ind_en;
      logic     res_cross;
      logic     src_cross;
      logic     exec_cond;
      bbtc_op_t op;
   } bbtc_ctrl_t;

   // Condition flags
   typedef struct packed {
      logic neg;
      logic zero;
      logic error;
   } bbtc_flags_t;

   // Result word pair
   typedef struct packed {
      logic [15:0] hi;
      logic [15:0] lo;
   } bbtc_dword_t;

endpackage

`default_nettype wire

// *** rtl/bbtc_converter.sv ***
`timescale 1ns/1ps
`include "bbtc_defs.svh"
`default_nettype none

module bbtc_converter
   import bbtc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o
);

   // Register state
   bbtc_ctrl_t  ctrl_ff;
   bbtc_ctrl_t  nxt_ctrl;
   logic [15:0] src0_ff;
   logic [15:0] nxt_src0;
   logic [15:0] src1_ff;
   logic [15:0] nxt_src1;
   logic [15:0] ptr_ff;
   logic [15:0] nxt_ptr;
   bbtc_dword_t res_ff;
   bbtc_dword_t nxt_res;
   bbtc_flags_t flags_ff;
   bbtc_flags_t nxt_flags;
   logic [1:0]  irq_stat_ff;
   logic [1:0]  nxt_irq_stat;
   logic [1:0]  irq_mask_ff;
   logic [1:0]  nxt_irq_mask;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic [1:0]  rd_stat_ff;
   logic [1:0]  nxt_rd_stat;

   // Bus decode and datapath nets
   logic        setup_phase;
   logic        access_wr;
   logic        access_rd;
   logic        addr_hit;
   logic        go;
   logic [31:0] rd_mux;
   logic [31:0] src_pair;
   logic        src0_dec;
   logic        src1_dec;
   logic        ptr_dec;
   logic        ind_err;
   logic [31:0] conv_val;
   logic        conv_err;
   logic        conv_skip;
   logic [31:0] sec_total;

   // True when all four nibbles hold decimal digits
   function automatic logic is_dec16(input logic [15:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (w[i*4 +: 4] > 4'h9) begin
            ok = 1'b0;
         end
      end
      return ok;
   endfunction

   // Packed decimal digits to binary, most significant digit first
   function automatic logic [31:0] dec_to_bin(input logic [31:0] d);
      logic [31:0] acc;
      acc = 32'h00000000;
      for (int i = 7; i >= 0; i--) begin
         acc = 32'(acc * 32'h0000000A) + {28'h0000000, d[i*4 +: 4]};
      end
      return acc;
   endfunction

   // Binary to eight packed digits by shift and add three
   function automatic logic [31:0] bin_to_dec(input logic [31:0] b);
      logic [63:0] sh;
      sh = {32'h00000000, b};
      for (int i = 0; i < 32; i++) begin
         for (int j = 0; j < 8; j++) begin
            if (sh[32 + j*4 +: 4] > 4'h4) begin
               sh[32 + j*4 +: 4] = sh[32 + j*4 +: 4] + 4'h3;
            end
         end
         sh = {sh[62:0], 1'b0};
      end
      return sh[63:32];
   endfunction

   // APB phase decode; the slave answers with no wait states
   assign setup_phase = psel_i && !penable_i;
   assign access_wr   = psel_i && penable_i && pwrite_i;
   assign access_rd   = psel_i && penable_i && !pwrite_i;
   assign pready_o    = 1'b1;
   assign pslverr_o   = psel_i && penable_i && !addr_hit;
   assign prdata_o    = prdata_ff;
   assign go          = access_wr && (paddr_i == `BBTC_CMD_OFS) && pstrb_i[0] && pwdata_i[`BBTC_CMD_GO_BIT];

   // Address map check
   always_comb begin
      case (paddr_i)
         `BBTC_CTRL_OFS, `BBTC_CMD_OFS, `BBTC_SRC0_OFS, `BBTC_SRC1_OFS, `BBTC_PTR_OFS,
         `BBTC_RES0_OFS, `BBTC_RES1_OFS, `BBTC_FLAGS_OFS, `BBTC_IRQ_STAT_OFS,
         `BBTC_IRQ_MASK_OFS: addr_hit = 1'b1;
         default: addr_hit = 1'b0;
      endcase
   end

   // Read data selection, unmapped reads give zero
   always_comb begin
      case (paddr_i)
         `BBTC_CTRL_OFS:     rd_mux = {25'h0000000, ctrl_ff};
         `BBTC_SRC0_OFS:     rd_mux = {16'h0000, src0_ff};
         `BBTC_SRC1_OFS:     rd_mux = {16'h0000, src1_ff};
         `BBTC_PTR_OFS:      rd_mux = {16'h0000, ptr_ff};
         `BBTC_RES0_OFS:     rd_mux = {16'h0000, res_ff.lo};
         `BBTC_RES1_OFS:     rd_mux = {16'h0000, res_ff.hi};
         `BBTC_FLAGS_OFS:    rd_mux = {29'h00000000, flags_ff};
         `BBTC_IRQ_STAT_OFS: rd_mux = {30'h00000000, irq_stat_ff};
         `BBTC_IRQ_MASK_OFS: rd_mux = {30'h00000000, irq_mask_ff};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   // Source checks shared by the conversions
   assign src_pair = {src1_ff, src0_ff};
   assign src0_dec = is_dec16(src0_ff);
   assign src1_dec = is_dec16(src1_ff);
   assign ptr_dec  = is_dec16(ptr_ff);
   assign ind_err  = ctrl_ff.ind_en && (!ptr_dec || ctrl_ff.ind_range_err);

   // Hours times 3600 plus minutes times 60 plus seconds
   always_comb begin
      sec_total = 32'(dec_to_bin({16'h0000, src1_ff}) * `BBTC_SEC_PER_HOUR)
                + 32'(dec_to_bin({24'h000000, src0_ff[15:8]}) * `BBTC_SEC_PER_MIN)
                + dec_to_bin({24'h000000, src0_ff[7:0]});
   end

   // Conversion result, error and skip per selected operation
   always_comb begin
      conv_val  = 32'h00000000;
      conv_err  = ind_err;
      conv_skip = 1'b0;
      case (ctrl_ff.op)
         BBTC_OP_WORD_BIN_TO_DEC: begin
            conv_val = bin_to_dec({16'h0000, src0_ff});
            if (src0_ff > `BBTC_BCD16_MAX) begin
               conv_err  = 1'b1;
               conv_skip = 1'b1;
            end
         end
         BBTC_OP_DWORD_DEC_TO_BIN: begin
            conv_val = dec_to_bin(src_pair);
            if (!src0_dec || !src1_dec) begin
               conv_err = 1'b1;
            end
         end
         BBTC_OP_DWORD_BIN_TO_DEC: begin
            conv_val = bin_to_dec(src_pair);
            if (src_pair > `BBTC_BCD32_MAX) begin
               conv_err  = 1'b1;
               conv_skip = 1'b1;
            end
         end
         BBTC_OP_TIME_TO_SEC: begin
            conv_val = bin_to_dec(sec_total);
            if (!src0_dec || !src1_dec) begin
               conv_err = 1'b1;
            end
            if (src0_ff[7:0] > `BBTC_SEXA_MAX || src0_ff[15:8] > `BBTC_SEXA_MAX) begin
               conv_err = 1'b1;
            end
            if (ctrl_ff.src_cross || ctrl_ff.res_cross) begin
               conv_err = 1'b1;
            end
         end
         default: begin
            conv_err = 1'b1;
         end
      endcase
   end

   // Register writes and conversion execution
   always_comb begin
      nxt_ctrl     = ctrl_ff;
      nxt_src0     = src0_ff;
      nxt_src1     = src1_ff;
      nxt_ptr      = ptr_ff;
      nxt_res      = res_ff;
      nxt_flags    = flags_ff;
      nxt_irq_mask = irq_mask_ff;
      if (access_wr) begin
         case (paddr_i)
            `BBTC_CTRL_OFS: begin
               if (pstrb_i[0]) begin
                  nxt_ctrl = bbtc_ctrl_t'(pwdata_i[6:0]);
               end
            end
            `BBTC_SRC0_OFS: begin
               if (pstrb_i[0]) nxt_src0[7:0]  = pwdata_i[7:0];
               if (pstrb_i[1]) nxt_src0[15:8] = pwdata_i[15:8];
            end
            `BBTC_SRC1_OFS: begin
               if (pstrb_i[0]) nxt_src1[7:0]  = pwdata_i[7:0];
               if (pstrb_i[1]) nxt_src1[15:8] = pwdata_i[15:8];
            end
            `BBTC_PTR_OFS: begin
               if (pstrb_i[0]) nxt_ptr[7:0]  = pwdata_i[7:0];
               if (pstrb_i[1]) nxt_ptr[15:8] = pwdata_i[15:8];
            end
            `BBTC_RES0_OFS: begin
               if (pstrb_i[0]) nxt_res.lo[7:0]  = pwdata_i[7:0];
               if (pstrb_i[1]) nxt_res.lo[15:8] = pwdata_i[15:8];
            end
            `BBTC_RES1_OFS: begin
               if (pstrb_i[0]) nxt_res.hi[7:0]  = pwdata_i[7:0];
               if (pstrb_i[1]) nxt_res.hi[15:8] = pwdata_i[15:8];
            end
            `BBTC_IRQ_MASK_OFS: begin
               if (pstrb_i[0]) begin
                  nxt_irq_mask = pwdata_i[1:0];
               end
            end
            default: begin
               nxt_ctrl = ctrl_ff;
            end
         endcase
      end
      // Execution uses control and sources as they stood before this write
      if (go && ctrl_ff.exec_cond) begin
         nxt_flags.error = conv_err;
         nxt_flags.zero  = !conv_err && (conv_val == 32'h00000000);
         if (ctrl_ff.op == BBTC_OP_DWORD_DEC_TO_BIN) begin
            nxt_flags.neg = 1'b0;
         end
         if (!conv_err && !conv_skip) begin
            nxt_res.lo = conv_val[15:0];
            if (ctrl_ff.op != BBTC_OP_WORD_BIN_TO_DEC) begin
               nxt_res.hi = conv_val[31:16];
            end
         end
      end
   end

   // Read capture in setup, sticky events with read clear
   always_comb begin
      nxt_prdata   = prdata_ff;
      nxt_rd_stat  = 2'h0;
      nxt_irq_stat = irq_stat_ff;
      if (setup_phase && !pwrite_i) begin
         nxt_prdata  = rd_mux;
         nxt_rd_stat = (paddr_i == `BBTC_IRQ_STAT_OFS) ? irq_stat_ff : 2'h0;
      end
      // Only bits that were returned are cleared; new events win
      if (access_rd && paddr_i == `BBTC_IRQ_STAT_OFS) begin
         nxt_irq_stat = irq_stat_ff & ~rd_stat_ff;
      end
      if (go && ctrl_ff.exec_cond) begin
         nxt_irq_stat[`BBTC_IRQ_DONE_BIT] = 1'b1;
         if (conv_err) begin
            nxt_irq_stat[`BBTC_IRQ_ERR_BIT] = 1'b1;
         end
      end
   end

   // Level interrupt from unmasked status bits
   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   // State registers
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         ctrl_ff     <= '0;
         src0_ff     <= `BBTC_WORD_RST;
         src1_ff     <= `BBTC_WORD_RST;
         ptr_ff      <= `BBTC_WORD_RST;
         res_ff      <= '0;
         flags_ff    <= '0;
         irq_stat_ff <= `BBTC_IRQ_RST;
         irq_mask_ff <= `BBTC_IRQ_RST;
         prdata_ff   <= 32'h00000000;
         rd_stat_ff  <= 2'h0;
      end else begin
         ctrl_ff     <= nxt_ctrl;
         src0_ff     <= nxt_src0;
         src1_ff     <= nxt_src1;
         ptr_ff      <= nxt_ptr;
         res_ff      <= nxt_res;
         flags_ff    <= nxt_flags;
         irq_stat_ff <= nxt_irq_stat;
         irq_mask_ff <= nxt_irq_mask;
         prdata_ff   <= nxt_prdata;
         rd_stat_ff  <= nxt_rd_stat;
      end
   end

endmodule // bbtc_converter

`default_nettype wire

// *** sim/bbtc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module bbtc_checker
   import bbtc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   input  wire logic [31:0] prdata_o,
   input  wire logic        pready_o,
   input  wire logic        pslverr_o,
   input  wire logic        irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic mapped;
   // Word offsets from control up to mask
   assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= 8'h24);
   sequence acc_s; psel_i && penable_i; endsequence
   sequence rd_s(a); psel_i && penable_i && !pwrite_i && paddr_i == a; endsequence
   sequence wr_s(a); psel_i && penable_i && pwrite_i && paddr_i == a; endsequence
   ready_high_a: assert property (pready_o) else $error("pready low");
   unmapped_err_a: assert property (acc_s ##0 !mapped |-> pslverr_o) else $error("no slave error");
   mapped_ok_a: assert property (acc_s ##0 mapped |-> !pslverr_o) else $error("bad slave error");
   err_idle_a: assert property (!(psel_i && penable_i) |-> !pslverr_o) else $error("slave error outside access");
   unmapped_rd_a: assert property (acc_s ##0 !mapped && !pwrite_i |-> prdata_o == 32'h0)
      else $error("unmapped read data");
   neg_low_a: assert property (rd_s(`BBTC_FLAGS_OFS) |-> prdata_o[31:2] == 30'h0)
      else $error("neg flag set");
   flag_excl_a: assert property (rd_s(`BBTC_FLAGS_OFS) |-> !(prdata_o[0] && prdata_o[1]))
      else $error("zero with error");
   irq_pair_a: assert property (rd_s(`BBTC_IRQ_STAT_OFS) |-> !(prdata_o[1] && !prdata_o[0]))
      else $error("error event without done");
   irq_rise_a: assert property ($rose(irq_o) |-> $past(psel_i && penable_i && pwrite_i
      && ((paddr_i == `BBTC_CMD_OFS && pwdata_i[0]) || paddr_i == `BBTC_IRQ_MASK_OFS)))
      else $error("irq rose without cause");
   irq_fall_a: assert property ($fell(irq_o) |-> !$past(rstn_i) || $past(psel_i && penable_i
      && paddr_i == (pwrite_i ? `BBTC_IRQ_MASK_OFS : `BBTC_IRQ_STAT_OFS))) else $error("irq fell");
endmodule // bbtc_checker

bind bbtc_converter bbtc_checker u_chk (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .irq_o);

`default_nettype wire

// *** sim/bbtc_apb_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module bbtc_apb_master (
   input  wire logic        clk_i,
   input  wire logic        pready_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic [7:0]       paddr_o,
   output logic [31:0]      pwdata_o,
   output logic [3:0]       pstrb_o
);
   // Idle bus at time zero
   initial begin
      {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o, pstrb_o} = '0;
   end
   // One transfer, held until pready is seen
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= w;
      paddr_o   <= a;
      pwdata_o  <= d;
      pstrb_o   <= 4'hF;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
   endtask
endmodule // bbtc_apb_master

`default_nettype wire

// *** sim/bbtc_converter_bench.sv ***
`timescale 1ns/1ps
`include "bbtc_defs.svh"
`default_nettype none

module bbtc_converter_bench
   import bbtc_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, b, v;
   logic [3:0]  pstrb, dg;
   logic [31:0] exp_q[$];
   int          bad_count = 0;
   int          total_checks = 0;
   localparam logic [15:0] P0 = 16'h1234, P1 = 16'h5678;

   always #2.5 clk_i = ~clk_i;

   bbtc_apb_master u_bbtc_apb_master (.clk_i(clk_i), .pready_i(pready), .psel_o(psel), .penable_o(penable),
      .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));
   bbtc_converter u_bbtc_converter (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [15:0] d);
      u_bbtc_apb_master.xfer(1'b1, a, {16'h0000, d});
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back({16'h0000, e});
      u_bbtc_apb_master.xfer(1'b0, a, 32'h0);
   endtask
   task ci(input logic e);
      #1 chk({31'h0, irq}, {31'h0, e});
   endtask
   function automatic logic [6:0] ct(bbtc_op_t o, logic [3:0] x);
      return {x, 1'b1, o};
   endfunction
   // Preset results, convert, read back results, flags and source
   task cv(input logic [6:0] c, input logic [15:0] s0, s1, e0, e1, input logic [2:0] f);
      wr(`BBTC_RES0_OFS, P0);
      wr(`BBTC_RES1_OFS, P1);
      wr(`BBTC_CTRL_OFS, {9'h000, c});
      wr(`BBTC_SRC0_OFS, s0);
      wr(`BBTC_SRC1_OFS, s1);
      wr(`BBTC_CMD_OFS, 16'h0001);
      rd(`BBTC_RES0_OFS, e0);
      rd(`BBTC_RES1_OFS, e1);
      rd(`BBTC_FLAGS_OFS, {13'h0000, f});
      rd(`BBTC_SRC0_OFS, s0);
   endtask

   // Read monitor takes the oldest note per completed read
   always @(posedge clk_i) begin
      if (psel && penable && pready && !pwrite) chk(prdata, exp_q.size() ? exp_q.pop_front() : 32'hDEADBEEF);
      // Only the probe offset lies outside the map
      if (psel && penable && pready) chk({31'h0, pslverr}, {31'h0, paddr == 8'h30});
   end

   // Main sequence
   initial begin
      void'($urandom(32'hB23FEB1C));
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      cv(7'h01, 16'h5678, 16'h1234, P0, P1, 3'h0);
      rd(`BBTC_IRQ_STAT_OFS, 16'h0000);
      cv(ct(BBTC_OP_DWORD_DEC_TO_BIN, 4'h0), 16'h5678, 16'h1234, 16'h614E, 16'h00BC, 3'h0);
      cv(ct(BBTC_OP_DWORD_DEC_TO_BIN, 4'h0), 16'h0, 16'h0, 16'h0, 16'h0, 3'h2);
      cv(ct(BBTC_OP_DWORD_DEC_TO_BIN, 4'h0), 16'h5678, 16'h12A4, P0, P1, 3'h1);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'h0), 16'h270F, 16'h0, 16'h9999, P1, 3'h0);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'h0), 16'h2710, 16'h0, P0, P1, 3'h1);
      cv(ct(BBTC_OP_DWORD_BIN_TO_DEC, 4'h0), 16'hE0FF, 16'h05F5, 16'h9999, 16'h9999, 3'h0);
      cv(ct(BBTC_OP_DWORD_BIN_TO_DEC, 4'h0), 16'hE100, 16'h05F5, P0, P1, 3'h1);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h0), 16'h5959, 16'h9999, 16'h9999, 16'h3599, 3'h0);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h0), 16'h0100, 16'h0001, 16'h3660, 16'h0000, 3'h0);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h0), 16'h6000, 16'h0, P0, P1, 3'h1);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h0), 16'h000A, 16'h0, P0, P1, 3'h1);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h0), 16'h0000, 16'h00B0, P0, P1, 3'h1);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h1), 16'h0001, 16'h0, P0, P1, 3'h1);
      cv(ct(BBTC_OP_TIME_TO_SEC, 4'h2), 16'h0001, 16'h0, P0, P1, 3'h1);
      wr(`BBTC_PTR_OFS, 16'h00A0);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'h4), 16'h0001, 16'h0, P0, P1, 3'h1);
      wr(`BBTC_PTR_OFS, 16'h0010);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'h4), 16'h0001, 16'h0, 16'h0001, P1, 3'h0);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'hC), 16'h0001, 16'h0, P0, P1, 3'h1);
      // Random eight-digit values
      repeat (4) begin
         b = 32'h0;
         v = 32'h0;
         repeat (8) begin
            dg = 4'($urandom % 10);
            b = {b[27:0], dg};
            v = v * 10 + dg;
         end
         cv(ct(BBTC_OP_DWORD_DEC_TO_BIN, 4'h0), b[15:0], b[31:16], v[15:0], v[31:16], 3'h0);
      end
      $display("conversions done");
      ci(1'b0);
      wr(`BBTC_IRQ_MASK_OFS, 16'h0003);
      ci(1'b1);
      rd(`BBTC_IRQ_STAT_OFS, 16'h0003);
      ci(1'b0);
      rd(`BBTC_IRQ_STAT_OFS, 16'h0000);
      cv(ct(BBTC_OP_WORD_BIN_TO_DEC, 4'h0), 16'h0000, 16'h0, 16'h0000, P1, 3'h2);
      ci(1'b1);
      wr(`BBTC_IRQ_MASK_OFS, 16'h0002);
      ci(1'b0);
      rd(`BBTC_IRQ_MASK_OFS, 16'h0002);
      rd(`BBTC_IRQ_STAT_OFS, 16'h0001);
      rd(8'h30, 16'h0000);
      $display("interrupts done");
      repeat (2) @(posedge clk_i);
      conclude();
   end

   // Watchdog
   initial begin
      #50000;
      bad_count++;
      conclude();
   end
endmodule // bbtc_converter_bench

`default_nettype wire
